// ==== design/hbp_dev_end.sv ====
// hbp_dev_end: device end of the host bus port, with its data fifo module
`timescale 1ns/1ns

// ============================================================================
// fifo with valid/ready on both sides
module hbp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("hbp_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg, wr_ptr_next;
  logic [PW-1:0]    rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0]    count_reg, count_next;
  logic             push, pop;

  // flags come straight from the count, so full and empty never lie
  assign in_ready  = (count_reg != CW'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer and count updates
  always_comb begin
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    count_next  = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // storage needs no reset; only entries below the count are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
endmodule

// ============================================================================
// device end
module hbp_dev_end #(
  parameter int FIFO_DEPTH = hbp_pkg::FIFO_DEPTH
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  hbp_bus_if.device                       bus,
  input  wire logic [hbp_pkg::DATA_W-1:0] rx_data,
  input  wire logic                       rx_valid,
  output logic                            rx_ready,
  output logic [hbp_pkg::DATA_W-1:0]      tx_data,
  output logic                            tx_valid,
  input  wire logic                       tx_ready,
  output logic [hbp_pkg::ADDR_W-1:0]      csr_addr,
  output logic [hbp_pkg::DATA_W-1:0]      csr_wdata,
  output logic                            csr_wr,
  output logic                            csr_rd,
  input  wire logic [hbp_pkg::DATA_W-1:0] csr_rdata
);
  localparam int DW = hbp_pkg::DATA_W;
  localparam int AW = hbp_pkg::ADDR_W;
  localparam int PINS_W = 5 + AW + DW;
  // idle pin image: select and strobes high, data wires pulled up
  localparam logic [PINS_W-1:0] PIN_IDLE = {3'h7, 2'h0, {AW{1'b0}}, hbp_pkg::BUS_IDLE_DATA};

  // byte order on the wires; little endian passes straight through
  function automatic logic [DW-1:0] order_bytes(input logic [DW-1:0] d, input logic big);
    order_bytes = big ? {d[7:0], d[15:8]} : d;
  endfunction

  // ==========================================================================
  // pin synchronisers: three flops, a change counts once stages two and three agree
  logic [PINS_W-1:0] pins_raw;
  logic [PINS_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;

  assign pins_raw = {bus.chip_select_n, bus.read_strobe_n, bus.write_strobe_n,
                     bus.fifo_direct, bus.big_endian, bus.addr, bus.data_bus};

  for (genvar i = 0; i < PINS_W; i++) begin : g_filt
    always_comb begin
      filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : filt_reg[i];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg   <= PIN_IDLE;
      s2_reg   <= PIN_IDLE;
      s3_reg   <= PIN_IDLE;
      filt_reg <= PIN_IDLE;
    end else begin
      s1_reg   <= pins_raw;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  logic          cs_act, rd_act, wr_act, direct_f, big_f;
  logic [AW-1:0] addr_f;
  logic [DW-1:0] data_f;

  // strobes only count with chip select low
  assign cs_act   = ~filt_reg[PINS_W-1];
  assign rd_act   = cs_act & ~filt_reg[PINS_W-2];
  assign wr_act   = cs_act & ~filt_reg[PINS_W-3];
  assign direct_f = filt_reg[PINS_W-4];
  assign big_f    = filt_reg[PINS_W-5];
  assign addr_f   = filt_reg[DW +: AW];
  assign data_f   = filt_reg[DW-1:0];

  // ==========================================================================
  // data fifos: receive filled by the user, transmit drained by the user
  logic [DW-1:0] rxf_data;
  logic          rxf_valid, rxf_pop;
  logic          txf_ready, txf_push;
  logic [DW-1:0] txf_data_reg, txf_data_next;

  hbp_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (rx_data),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .out_data  (rxf_data),
    .out_valid (rxf_valid),
    .out_ready (rxf_pop)
  );

  hbp_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (txf_data_reg),
    .in_valid  (txf_push),
    .in_ready  (txf_ready),
    .out_data  (tx_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready)
  );

  // ==========================================================================
  // access state machine
  hbp_pkg::hbp_dev_state_e state_reg, state_next;
  logic [DW-1:0] dout_reg, dout_next;
  logic          oe_reg, oe_next;
  logic          big_reg, big_next;
  logic          to_tx_reg, to_tx_next;
  logic [AW-1:0] addr_reg, addr_next;
  logic [DW-1:0] wdata_reg, wdata_next;
  logic          csr_wr_reg, csr_wr_next;
  logic          csr_rd_reg, csr_rd_next;

  assign rxf_pop  = (state_reg == hbp_pkg::DEV_IDLE) && rd_act && !wr_act && rxf_valid
                    && (direct_f || addr_f == hbp_pkg::RX_FIFO_ADDR);
  assign txf_push = (state_reg == hbp_pkg::DEV_PUSH) && txf_ready;
  // push word follows the ordered write data while the write is open
  assign txf_data_next = (state_reg == hbp_pkg::DEV_WRITE) ? wdata_next : txf_data_reg;

  always_comb begin
    state_next  = state_reg;
    dout_next   = dout_reg;
    oe_next     = oe_reg;
    big_next    = big_reg;
    to_tx_next  = to_tx_reg;
    addr_next   = addr_reg;
    wdata_next  = wdata_reg;
    csr_wr_next = 1'b0;
    csr_rd_next = 1'b0;
    case (state_reg)
      hbp_pkg::DEV_IDLE: begin
        // a read and a write seen together is undefined; neither is taken
        if (rd_act && !wr_act) begin
          oe_next  = 1'b1;
          big_next = big_f;
          if (direct_f || addr_f == hbp_pkg::RX_FIFO_ADDR) begin
            dout_next = rxf_valid ? order_bytes(rxf_data, big_f) : hbp_pkg::EMPTY_READ_DATA;
          end else if (addr_f == hbp_pkg::TX_FIFO_ADDR) begin
            dout_next = hbp_pkg::EMPTY_READ_DATA;
          end else begin
            dout_next   = order_bytes(csr_rdata, big_f);
            csr_rd_next = 1'b1;
            addr_next   = addr_f;
          end
          state_next = hbp_pkg::DEV_READ;
        end else if (wr_act && !rd_act) begin
          big_next   = big_f;
          addr_next  = addr_f;
          to_tx_next = direct_f || addr_f == hbp_pkg::TX_FIFO_ADDR;
          state_next = hbp_pkg::DEV_WRITE;
        end
      end
      hbp_pkg::DEV_READ: begin
        // drive the wires only while the qualified read lasts
        if (!rd_act) begin
          oe_next    = 1'b0;
          state_next = hbp_pkg::DEV_IDLE;
        end
      end
      hbp_pkg::DEV_WRITE: begin
        // sram style: data is taken at the trailing edge of the strobe
        if (!wr_act) begin
          wdata_next = order_bytes(data_f, big_reg);
          if (to_tx_reg) begin
            state_next = hbp_pkg::DEV_PUSH;
          end else if (addr_reg != hbp_pkg::RX_FIFO_ADDR) begin
            csr_wr_next = 1'b1;
            state_next  = hbp_pkg::DEV_IDLE;
          end else begin
            state_next = hbp_pkg::DEV_IDLE;
          end
        end
      end
      hbp_pkg::DEV_PUSH: begin
        // a full transmit fifo stalls here; new accesses wait for the space
        if (txf_ready) begin
          state_next = hbp_pkg::DEV_IDLE;
        end
      end
      default: begin
        state_next = hbp_pkg::DEV_IDLE;
        oe_next    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg    <= hbp_pkg::DEV_IDLE;
      dout_reg     <= '0;
      oe_reg       <= 1'b0;
      big_reg      <= 1'b0;
      to_tx_reg    <= 1'b0;
      addr_reg     <= '0;
      wdata_reg    <= '0;
      txf_data_reg <= '0;
      csr_wr_reg   <= 1'b0;
      csr_rd_reg   <= 1'b0;
    end else begin
      state_reg    <= state_next;
      dout_reg     <= dout_next;
      oe_reg       <= oe_next;
      big_reg      <= big_next;
      to_tx_reg    <= to_tx_next;
      addr_reg     <= addr_next;
      wdata_reg    <= wdata_next;
      txf_data_reg <= txf_data_next;
      csr_wr_reg   <= csr_wr_next;
      csr_rd_reg   <= csr_rd_next;
    end
  end

  // outputs
  assign bus.dev_d_out = dout_reg;
  assign bus.dev_d_oe  = oe_reg;
  assign csr_addr      = addr_reg;
  assign csr_wdata     = wdata_reg;
  assign csr_wr        = csr_wr_reg;
  assign csr_rd        = csr_rd_reg;
endmodule

// ==== design/hbp_host_end.sv ====
// hbp_host_end: host end that runs sram-like cycles on the host bus port
`timescale 1ns/1ns
module hbp_host_end (
  input  wire logic                       clk,
  input  wire logic                       rst,
  hbp_bus_if.host                         bus,
  input  wire logic                       cmd_valid,
  output logic                            cmd_ready,
  input  wire logic                       cmd_write,
  input  wire logic [hbp_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [hbp_pkg::DATA_W-1:0] cmd_wdata,
  input  wire logic                       fifo_direct_in,
  input  wire logic                       big_endian_in,
  output logic                            rsp_valid,
  output logic [hbp_pkg::DATA_W-1:0]      rsp_rdata
);
  localparam int DW = hbp_pkg::DATA_W;
  localparam int CW = hbp_pkg::CNT_W;

  // ==========================================================================
  // read data synchroniser, three flops with agreement filter
  logic [DW-1:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_next;

  for (genvar i = 0; i < DW; i++) begin : g_filt
    always_comb begin
      filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : filt_reg[i];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg   <= hbp_pkg::BUS_IDLE_DATA;
      s2_reg   <= hbp_pkg::BUS_IDLE_DATA;
      s3_reg   <= hbp_pkg::BUS_IDLE_DATA;
      filt_reg <= hbp_pkg::BUS_IDLE_DATA;
    end else begin
      s1_reg   <= bus.data_bus;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  // ==========================================================================
  // cycle sequencer: setup, strobe, recover
  hbp_pkg::hbp_host_state_e state_reg, state_next;
  logic [CW-1:0]               cnt_reg, cnt_next;
  logic                        write_reg, write_next;
  logic [hbp_pkg::ADDR_W-1:0]  addr_reg, addr_next;
  logic [DW-1:0]               wdata_reg, wdata_next;
  logic                        direct_reg, direct_next;
  logic                        big_reg, big_next;
  logic                        cs_n_reg, cs_n_next;
  logic                        rd_n_reg, rd_n_next;
  logic                        wr_n_reg, wr_n_next;
  logic                        oe_reg, oe_next;
  logic                        rsp_valid_reg, rsp_valid_next;
  logic [DW-1:0]               rdata_reg, rdata_next;

  assign cmd_ready = (state_reg == hbp_pkg::HOST_IDLE);

  always_comb begin
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    write_next     = write_reg;
    addr_next      = addr_reg;
    wdata_next     = wdata_reg;
    direct_next    = direct_reg;
    big_next       = big_reg;
    cs_n_next      = cs_n_reg;
    rd_n_next      = rd_n_reg;
    wr_n_next      = wr_n_reg;
    oe_next        = oe_reg;
    rsp_valid_next = 1'b0;
    rdata_next     = rdata_reg;
    case (state_reg)
      hbp_pkg::HOST_IDLE: begin
        // mode pins only move between accesses
        direct_next = fifo_direct_in;
        big_next    = big_endian_in;
        oe_next     = 1'b0;
        if (cmd_valid) begin
          write_next = cmd_write;
          addr_next  = cmd_addr;
          wdata_next = cmd_wdata;
          cs_n_next  = 1'b0;
          oe_next    = cmd_write;
          cnt_next   = CW'(hbp_pkg::SETUP_CYC - 1);
          state_next = hbp_pkg::HOST_SETUP;
        end
      end
      hbp_pkg::HOST_SETUP: begin
        if (cnt_reg == '0) begin
          // only one strobe ever goes low
          rd_n_next  = write_reg;
          wr_n_next  = ~write_reg;
          cnt_next   = CW'(hbp_pkg::STROBE_CYC - 1);
          state_next = hbp_pkg::HOST_STROBE;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      hbp_pkg::HOST_STROBE: begin
        if (cnt_reg == '0) begin
          rd_n_next = 1'b1;
          wr_n_next = 1'b1;
          cs_n_next = 1'b1;
          if (!write_reg) begin
            rdata_next     = filt_reg;
            rsp_valid_next = 1'b1;
          end
          cnt_next   = CW'(hbp_pkg::RECOVER_CYC - 1);
          state_next = hbp_pkg::HOST_RECOVER;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      hbp_pkg::HOST_RECOVER: begin
        // write data held on so the device still sees it at strobe release
        if (cnt_reg == '0) begin
          oe_next    = 1'b0;
          state_next = hbp_pkg::HOST_IDLE;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: begin
        state_next = hbp_pkg::HOST_IDLE;
        cs_n_next  = 1'b1;
        rd_n_next  = 1'b1;
        wr_n_next  = 1'b1;
        oe_next    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg     <= hbp_pkg::HOST_IDLE;
      cnt_reg       <= '0;
      write_reg     <= 1'b0;
      addr_reg      <= '0;
      wdata_reg     <= '0;
      direct_reg    <= 1'b0;
      big_reg       <= 1'b0;
      cs_n_reg      <= 1'b1;
      rd_n_reg      <= 1'b1;
      wr_n_reg      <= 1'b1;
      oe_reg        <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rdata_reg     <= '0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      write_reg     <= write_next;
      addr_reg      <= addr_next;
      wdata_reg     <= wdata_next;
      direct_reg    <= direct_next;
      big_reg       <= big_next;
      cs_n_reg      <= cs_n_next;
      rd_n_reg      <= rd_n_next;
      wr_n_reg      <= wr_n_next;
      oe_reg        <= oe_next;
      rsp_valid_reg <= rsp_valid_next;
      rdata_reg     <= rdata_next;
    end
  end

  // pins and answers, all from flops
  assign bus.chip_select_n  = cs_n_reg;
  assign bus.read_strobe_n  = rd_n_reg;
  assign bus.write_strobe_n = wr_n_reg;
  assign bus.addr           = addr_reg;
  assign bus.fifo_direct    = direct_reg;
  assign bus.big_endian     = big_reg;
  assign bus.host_d_out     = wdata_reg;
  assign bus.host_d_oe      = oe_reg;
  assign rsp_valid          = rsp_valid_reg;
  assign rsp_rdata          = rdata_reg;
endmodule

// ==== pkg/hbp_bus_if.sv ====
// hbp_bus_if: the pins between host and device, with the shared data wires
`timescale 1ns/1ns
interface hbp_bus_if;
  logic                          chip_select_n;
  logic                          read_strobe_n;
  logic                          write_strobe_n;
  logic [hbp_pkg::ADDR_W-1:0]    addr;
  logic                          fifo_direct;
  logic                          big_endian;
  logic [hbp_pkg::DATA_W-1:0]    host_d_out;
  logic                          host_d_oe;
  logic [hbp_pkg::DATA_W-1:0]    dev_d_out;
  logic                          dev_d_oe;
  logic [hbp_pkg::DATA_W-1:0]    data_bus;

  // wire level from the enables; undriven wires float high
  assign data_bus = dev_d_oe  ? dev_d_out  :
                    host_d_oe ? host_d_out : hbp_pkg::BUS_IDLE_DATA;

  modport device (
    input  chip_select_n,
    input  read_strobe_n,
    input  write_strobe_n,
    input  addr,
    input  fifo_direct,
    input  big_endian,
    input  data_bus,
    output dev_d_out,
    output dev_d_oe
  );

  modport host (
    output chip_select_n,
    output read_strobe_n,
    output write_strobe_n,
    output addr,
    output fifo_direct,
    output big_endian,
    output host_d_out,
    output host_d_oe,
    input  data_bus
  );
endinterface

// ==== pkg/hbp_pkg.sv ====
// hbp_pkg: shared constants and state types for the host bus port ends
package hbp_pkg;

  // ==========================================================================
  // bus geometry
  localparam int DATA_W     = 16;
  localparam int ADDR_W     = 9;
  localparam int FIFO_DEPTH = 8;

  // word addresses of the two data fifo ports; all other addresses are csrs unless fifo_direct is set
  localparam logic [ADDR_W-1:0] RX_FIFO_ADDR = 9'h000;
  localparam logic [ADDR_W-1:0] TX_FIFO_ADDR = 9'h010;

  // value seen on the data wires when nobody drives them (pull-ups)
  localparam logic [DATA_W-1:0] BUS_IDLE_DATA = 16'hFFFF;
  // value returned for a read of an empty fifo or of the write-only port
  localparam logic [DATA_W-1:0] EMPTY_READ_DATA = 16'h0000;

  // ==========================================================================
  // timing; least times, so cycle counts round up
  localparam int CLK_PERIOD_NS = 4;
  localparam int SETUP_NS      = 8;
  localparam int STROBE_NS     = 60;
  localparam int RECOVER_NS    = 40;
  localparam int SETUP_CYC     = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC   = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 8;

  // ==========================================================================
  // state machines
  typedef enum logic [3:0] {
    DEV_IDLE  = 4'h1,
    DEV_READ  = 4'h2,
    DEV_WRITE = 4'h4,
    DEV_PUSH  = 4'h8
  } hbp_dev_state_e;

  typedef enum logic [3:0] {
    HOST_IDLE    = 4'h1,
    HOST_SETUP   = 4'h2,
    HOST_STROBE  = 4'h4,
    HOST_RECOVER = 4'h8
  } hbp_host_state_e;

endpackage

// ==== tb/hbp_bus_chk.sv ====
// hbp_bus_chk: assertions on the wires between the host end and the device end
`timescale 1ns/1ns
module hbp_bus_chk (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic                       chip_select_n,
  input wire logic                       read_strobe_n,
  input wire logic                       write_strobe_n,
  input wire logic [hbp_pkg::ADDR_W-1:0] addr,
  input wire logic                       fifo_direct,
  input wire logic                       big_endian,
  input wire logic                       host_d_oe,
  input wire logic                       dev_d_oe
);
  // ==========================================================================
  // one clock domain, so clock and disable are given once
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  one_driver_a: assert property (!(dev_d_oe && host_d_oe))
    else $error("both ends drive the data wires");
  strobe_pair_a: assert property (read_strobe_n || write_strobe_n)
    else $error("read and write strobes low together");
  strobe_select_a: assert property (!(read_strobe_n && write_strobe_n) |-> !chip_select_n)
    else $error("strobe low without chip select");
  // the device filter lags the pins by a few edges, so allow a short window
  read_answer_a: assert property ($fell(read_strobe_n) |-> ##[1:12] dev_d_oe)
    else $error("device did not answer a read");
  answer_qual_a: assert property ($rose(dev_d_oe) |-> !chip_select_n && !read_strobe_n)
    else $error("device drove the bus outside a read");
  no_drive_write_a: assert property (dev_d_oe |-> write_strobe_n)
    else $error("device drove the bus during a write");
  write_hold_a: assert property ($fell(write_strobe_n) |->
    (!write_strobe_n && $stable(addr))[*8])
    else $error("write strobe or address not held");
  // mode pins may only change between accesses
  mode_hold_a: assert property (!chip_select_n && !$past(chip_select_n) |->
    $stable(fifo_direct) && $stable(big_endian))
    else $error("mode pins changed inside an access");

  cover property ($rose(dev_d_oe) && fifo_direct);
  cover property ($fell(write_strobe_n) && fifo_direct);
  cover property ($fell(read_strobe_n) && big_endian);
endmodule

// ==== tb/test_sram_like_host_bus_port.sv ====
// test_sram_like_host_bus_port: both ends joined, driven from their user sides
`timescale 1ns/1ns
module test_sram_like_host_bus_port;
  localparam int DW = hbp_pkg::DATA_W;
  logic          clk;
  logic          rst;
  logic          cmd_valid;
  logic          cmd_ready;
  logic          cmd_write;
  logic [8:0]    cmd_addr;
  logic [DW-1:0] cmd_wdata;
  logic          fifo_direct_in;
  logic          big_endian_in;
  logic          rsp_valid;
  logic [DW-1:0] rsp_rdata;
  logic [DW-1:0] rx_data;
  logic          rx_valid;
  logic          rx_ready;
  logic [DW-1:0] tx_data;
  logic          tx_valid;
  logic          tx_ready;
  logic [8:0]    csr_addr;
  logic [DW-1:0] csr_wdata;
  logic          csr_wr;
  logic          csr_rd;
  logic [DW-1:0] csr_rdata;
  logic [8:0]    wr_addr;
  logic [DW-1:0] wr_data;
  logic [DW-1:0] q;
  int            n_wr = 0;
  int            n_rd = 0;
  int            n_fail = 0;
  int            n_tests = 0;
  int            cyc = 0;

  hbp_bus_if i_hbp_bus_if ();
  hbp_host_end i_hbp_host_end (.clk(clk), .rst(rst), .bus(i_hbp_bus_if), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .fifo_direct_in(fifo_direct_in), .big_endian_in(big_endian_in), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata));
  hbp_dev_end i_hbp_dev_end (.clk(clk), .rst(rst), .bus(i_hbp_bus_if), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .csr_addr(csr_addr), .csr_wdata(csr_wdata), .csr_wr(csr_wr),
    .csr_rd(csr_rd), .csr_rdata(csr_rdata));
  hbp_bus_chk i_hbp_bus_chk (.clk(clk), .rst(rst), .chip_select_n(i_hbp_bus_if.chip_select_n),
    .read_strobe_n(i_hbp_bus_if.read_strobe_n), .write_strobe_n(i_hbp_bus_if.write_strobe_n),
    .addr(i_hbp_bus_if.addr), .fifo_direct(i_hbp_bus_if.fifo_direct),
    .big_endian(i_hbp_bus_if.big_endian), .host_d_oe(i_hbp_bus_if.host_d_oe),
    .dev_d_oe(i_hbp_bus_if.dev_d_oe));

  // register file stand-in: data follows the address on the pins, as the device samples early
  assign csr_rdata = {7'h00, i_hbp_bus_if.addr} ^ 16'hA5A5;

  // ==========================================================================
  // clock, capture of register writes, hang guard
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (csr_wr) begin
      wr_addr <= csr_addr;
      wr_data <= csr_wdata;
      n_wr <= n_wr + 1;
    end
    if (csr_rd) begin
      n_rd <= n_rd + 1;
    end
    if (cyc == 4000) begin
      n_fail++;
      results();
    end
  end

  function automatic logic [DW-1:0] sw(input logic [DW-1:0] x);
    return {x[7:0], x[15:8]};
  endfunction

  task automatic check(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // one host command; waits until the host end is idle again, so the device has settled
  task automatic host(input logic wr, input logic [8:0] a, input logic [DW-1:0] d,
                      input logic fd, input logic be);
    while (cmd_ready !== 1'b1) @(negedge clk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_wdata = d;
    fifo_direct_in = fd;
    big_endian_in = be;
    @(negedge clk);
    cmd_valid = 1'b0;
    while (!wr && rsp_valid !== 1'b1) @(negedge clk);
    q = rsp_rdata;
    while (cmd_ready !== 1'b1) @(negedge clk);
  endtask

  task automatic rd(input logic [8:0] a, input logic fd, input logic be, input logic [DW-1:0] e);
    host(1'b0, a, 16'h0000, fd, be);
    check("read data", q, e);
  endtask

  // pop one word from the transmit side
  task automatic pop(input logic [DW-1:0] e);
    check("tx_valid", {15'h0000, tx_valid}, 16'h0001);
    check("tx_data", tx_data, e);
    tx_ready = 1'b1;
    @(negedge clk);
    tx_ready = 1'b0;
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    {rst, cmd_valid, cmd_write, fifo_direct_in, big_endian_in, rx_valid, tx_ready} = 7'h40;
    cmd_addr = 9'h000;
    cmd_wdata = 16'h0000;
    rx_data = 16'h0000;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    host(1'b1, 9'h123, 16'h1234, 1'b0, 1'b0);
    check("csr_addr", {7'h00, wr_addr}, 16'h0123);
    check("csr_wdata", wr_data, 16'h1234);
    host(1'b1, 9'h1FF, 16'hABCD, 1'b0, 1'b1);
    check("csr_wdata", wr_data, 16'hCDAB);
    $display("test register writes done");
    rd(9'h0A5, 1'b0, 1'b0, 16'hA500);
    rd(9'h0A5, 1'b0, 1'b1, 16'h00A5);
    rd(9'h1C3, 1'b0, 1'b0, 16'hA466);
    rd(hbp_pkg::TX_FIFO_ADDR, 1'b0, 1'b0, hbp_pkg::EMPTY_READ_DATA);
    check("csr reads", n_rd[15:0], 16'h0003);
    $display("test register reads done");
    // far side stalls while three words go into the transmit buffer of eight
    host(1'b1, 9'h055, 16'h5A01, 1'b1, 1'b0);
    host(1'b1, 9'h123, 16'h1234, 1'b1, 1'b1);
    host(1'b1, hbp_pkg::RX_FIFO_ADDR, 16'h0BAD, 1'b0, 1'b0);
    host(1'b1, hbp_pkg::TX_FIFO_ADDR, 16'h7E81, 1'b0, 1'b0);
    check("csr writes", n_wr[15:0], 16'h0002);
    pop(16'h5A01);
    pop(16'h3412);
    pop(16'h7E81);
    check("tx_valid", {15'h0000, tx_valid}, 16'h0000);
    $display("test transmit path done");
    // nine offers into a buffer of eight: the last must be refused
    for (int i = 0; i < 9; i++) begin
      rx_valid = 1'b1;
      rx_data = 16'hC000 + i[15:0];
      @(negedge clk);
    end
    rx_valid = 1'b0;
    check("rx_ready", {15'h0000, rx_ready}, 16'h0000);
    rd(9'h1AB, 1'b1, 1'b1, 16'h00C0);
    rd(hbp_pkg::RX_FIFO_ADDR, 1'b0, 1'b0, 16'hC001);
    for (int i = 2; i < 8; i++) rd(9'h0A5, 1'b1, 1'b0, 16'hC000 + i[15:0]);
    rd(9'h1AB, 1'b1, 1'b0, hbp_pkg::EMPTY_READ_DATA);
    check("rx_ready", {15'h0000, rx_ready}, 16'h0001);
    check("csr reads", n_rd[15:0], 16'h0003);
    $display("test receive path done");
    results();
  end
endmodule
